//--- verilog/wit_pkg.sv
// package: register map, field layout, reset values and types of the watchdog interval timer
package wit_pkg;

    // register byte addresses
    localparam logic [7:0] ADDR_OVF_SEL   = 8'h00;
    localparam logic [7:0] ADDR_MODE_CTRL = 8'h04;
    localparam logic [7:0] ADDR_OSC_SEL   = 8'h08;
    localparam logic [7:0] ADDR_STATUS    = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_EN    = 8'h10;
    localparam logic [7:0] ADDR_IRQ_CLR   = 8'h14;
    localparam logic [7:0] ADDR_COUNT     = 8'h18;

    // field positions
    localparam int RUN_BIT       = 7;
    localparam int MODE_SEL_BIT  = 4;
    localparam int OVF_ACT_BIT   = 3;
    localparam int SEL_FIELD_LSB = 0;
    localparam int SEL_FIELD_W   = 3;

    // status bits
    localparam int ST_MASKABLE = 0;
    localparam int ST_NMI      = 1;
    localparam int ST_RESET    = 2;
    localparam int ST_W        = 3;

    // reset values
    localparam logic [7:0] OVF_SEL_RST   = 8'h00;
    localparam logic [7:0] MODE_CTRL_RST = 8'h00;
    localparam logic [7:0] OSC_SEL_RST   = 8'h04;

    // timing
    localparam int PRESCALE_BITS = 8;
    localparam int COUNT_BITS    = 12;
    localparam int CODE_MAX      = 7;
    localparam int MAX_SHIFT_TOP = 6;
    localparam int TOP_SHIFT     = 8;
    localparam int RESET_PULSE_CYC = 4;

    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum {
        WIT_INTERVAL,
        WIT_WDT_NMI,
        WIT_WDT_RESET
    } wit_mode_type;

    typedef struct packed {
        logic       maskableIrq;
        logic       nmiIrq;
        logic       systemReset;
        logic       pwmOffIrq;
    } wit_event_type;

    typedef struct packed {
        logic       awready;
        logic       wready;
        logic       bvalid;
        logic [1:0] bresp;
        logic       arready;
        logic       rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } wit_axi_out_type;

endpackage

//--- verilog/wit_prescaler.sv
// free-running prescaler giving a one-cycle enable every 2^8 system clocks
`timescale 1ns/1ps
module wit_prescaler
    import wit_pkg::*;
#(
    parameter int BITS = PRESCALE_BITS
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    // control
    input  wire logic countEnable,
    // enable out
    output logic      tick
);
    typedef struct packed {
        logic [BITS-1:0] count;
        logic            tick;
    } wit_pre_state_type;

    wit_pre_state_type state;
    wit_pre_state_type next_state;

    always_comb begin
        next_state = state;
        next_state.tick = 1'b0;
        if (countEnable) begin
            next_state.count = state.count + 1'b1;
            next_state.tick = &state.count;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign tick = state.tick;
endmodule

//--- verilog/wit_axi_slave.sv
// axi4-lite register access slave, one outstanding write and read
`timescale 1ns/1ps
module wit_axi_slave
    import wit_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // axi write channels
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    input  wire logic        bready,
    // axi read channels
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    input  wire logic        rready,
    // register side
    output logic             wrStrobe,
    output logic [7:0]       wrAddr,
    output logic [7:0]       wrData,
    output logic             rdStrobe,
    output logic [7:0]       rdAddr,
    input  wire logic [31:0] rdData,
    input  wire logic        rdHit,
    input  wire logic        wrHit,
    // axi outputs
    output wit_axi_out_type  axiOut
);
    typedef struct packed {
        logic            haveAw;
        logic            haveW;
        logic [7:0]      aw;
        logic [7:0]      wd;
        logic            wrOk;
        logic            wrGo;
        logic            rdGo;
        logic [7:0]      ar;
        wit_axi_out_type o;
    } wit_axi_state_type;

    wit_axi_state_type state;
    wit_axi_state_type next_state;

    always_comb begin
        next_state = state;
        next_state.wrGo = 1'b0;
        next_state.rdGo = 1'b0;
        next_state.o.awready = !state.haveAw && !state.o.bvalid;
        next_state.o.wready = !state.haveW && !state.o.bvalid;
        next_state.o.arready = !state.o.rvalid && !state.rdGo;
        if (awvalid && state.o.awready) begin
            next_state.haveAw = 1'b1;
            next_state.aw = awaddr;
            next_state.o.awready = 1'b0;
        end
        if (wvalid && state.o.wready) begin
            next_state.haveW = 1'b1;
            next_state.wd = wstrb[0] ? wdata[7:0] : 8'h00;
            next_state.wrOk = wstrb[0];
            next_state.o.wready = 1'b0;
        end
        if (state.haveAw && state.haveW && !state.o.bvalid) begin
            next_state.wrGo = state.wrOk;
            next_state.haveAw = 1'b0;
            next_state.haveW = 1'b0;
            next_state.o.bvalid = 1'b1;
            next_state.o.bresp = wrHit ? RESP_OKAY : RESP_SLVERR;
        end
        if (state.o.bvalid && bready) begin
            next_state.o.bvalid = 1'b0;
        end
        if (arvalid && state.o.arready) begin
            next_state.ar = araddr;
            next_state.rdGo = 1'b1;
            next_state.o.arready = 1'b0;
        end
        if (state.rdGo) begin
            next_state.o.rvalid = 1'b1;
            next_state.o.rdata = rdData;
            next_state.o.rresp = rdHit ? RESP_OKAY : RESP_SLVERR;
        end
        if (state.o.rvalid && rready) begin
            next_state.o.rvalid = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign wrStrobe = state.wrGo;
    assign wrAddr = state.aw;
    assign wrData = state.wd;
    assign rdStrobe = state.rdGo;
    assign rdAddr = state.rdGo ? state.ar : state.aw;
    assign axiOut = state.o;
endmodule

//--- verilog/wit_top.sv
// watchdog and interval timer with axi4-lite registers and interrupt status
//
// Overview of operation
// - mode select 0: interval timer, maskable irq at every overflow
// - mode select 1, action 0: non-maskable irq on overflow
// - mode select 1, action 1: system reset on overflow, no irq pulse; irq only via enabled status bit 2
// - run bit 0 stops counter; writing 1 clears counter and starts
// - mode select and action bits, once 1, ignore writes of 0
// - run bit once set cannot be cleared by software
// - free prescaler not reset on restart; first overflow up to 2^8 early
// - interval select field bits 0-2 chooses overflow period for both modes
// - codes 0-6 give 2^12..2^18 clocks, code 7 gives 2^20
// - reset clears overflow select and mode registers to 00H
// - reset loads oscillation settle select with 04H
// - counts in halt, holds count in stop
// - interval irqs begin as soon as run bit is written 1
// - one counter; mode select bit alone picks watchdog or interval
// - pwm-off signal follows overflow irq except in reset mode
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module wit_top
    import wit_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // cpu standby states
    input  wire logic        cpuHalt,
    input  wire logic        cpuStop,
    // axi write address
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    // axi write data
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    // axi write response
    output logic             bvalid,
    output logic [1:0]       bresp,
    input  wire logic        bready,
    // axi read address
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    // axi read data
    output logic             rvalid,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    input  wire logic        rready,
    // timer events
    output logic             overflowIrq,
    output logic             nmiRequest,
    output logic             systemResetReq,
    output logic             pwmOffIrq,
    output logic             irq,
    // oscillation settle select value
    output logic [7:0]       oscSettleSelect
);
    typedef struct packed {
        logic [7:0]            overflowTimeSelect;
        logic [7:0]            watchdogModeControl;
        logic [7:0]            oscSettle;
        logic [ST_W-1:0]       status;
        logic [ST_W-1:0]       irqEnable;
        logic [COUNT_BITS-1:0] count;
        wit_event_type         ev;
        logic [2:0]            resetHold;
        logic                  irq;
    } wit_state_type;

    wit_state_type   state;
    wit_state_type   next_state;
    wit_axi_out_type axiOut;
    logic            wrStrobe;
    logic [7:0]      wrAddr;
    logic [7:0]      wrData;
    logic            rdStrobe;
    logic [7:0]      rdAddr;
    logic [31:0]     rdData;
    logic            prescaleTick;
    logic            cpuStopMeta;
    logic            cpuStopSync;
    logic            cpuStopLate;
    logic            stopped;

    // decode of a mapped register address
    function automatic logic addrHit(input logic [7:0] a);
        case (a)
            ADDR_OVF_SEL, ADDR_MODE_CTRL, ADDR_OSC_SEL, ADDR_STATUS,
            ADDR_IRQ_EN, ADDR_IRQ_CLR, ADDR_COUNT: addrHit = 1'b1;
            default: addrHit = 1'b0;
        endcase
    endfunction

    // overflow position of the counter for an interval code
    function automatic logic [4:0] overflowShift(input logic [SEL_FIELD_W-1:0] code);
        if (code == 3'(CODE_MAX)) begin
            overflowShift = 5'(TOP_SHIFT + COUNT_BITS - PRESCALE_BITS);
        end else begin
            overflowShift = 5'(COUNT_BITS - PRESCALE_BITS) + 5'(code);
        end
    endfunction

    // stop state from outside domain, three stages, second and third agree
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cpuStopMeta <= 1'b0;
            cpuStopSync <= 1'b0;
            cpuStopLate <= 1'b0;
            stopped <= 1'b0;
        end else begin
            cpuStopMeta <= cpuStop;
            cpuStopSync <= cpuStopMeta;
            cpuStopLate <= cpuStopSync;
            if (cpuStopSync == cpuStopLate) begin
                stopped <= cpuStopLate;
            end
        end
    end

    // prescaler runs free of restarts, halt does not stop it
    wit_prescaler #(
        .BITS(PRESCALE_BITS)
    ) u_prescaler (
        .sys_clk     (sys_clk),
        .sys_rst     (sys_rst),
        .countEnable (!stopped),
        .tick        (prescaleTick)
    );

    wit_axi_slave u_axi (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .awaddr   (awaddr),
        .awvalid  (awvalid),
        .wdata    (wdata),
        .wstrb    (wstrb),
        .wvalid   (wvalid),
        .bready   (bready),
        .araddr   (araddr),
        .arvalid  (arvalid),
        .rready   (rready),
        .wrStrobe (wrStrobe),
        .wrAddr   (wrAddr),
        .wrData   (wrData),
        .rdStrobe (rdStrobe),
        .rdAddr   (rdAddr),
        .rdData   (rdData),
        .rdHit    (addrHit(rdAddr)),
        .wrHit    (addrHit(wrAddr)),
        .axiOut   (axiOut)
    );

    // read mux
    always_comb begin
        rdData = 32'h0000_0000;
        case (rdAddr)
            ADDR_OVF_SEL:   rdData[7:0] = state.overflowTimeSelect;
            ADDR_MODE_CTRL: rdData[7:0] = state.watchdogModeControl;
            ADDR_OSC_SEL:   rdData[7:0] = state.oscSettle;
            ADDR_STATUS:    rdData[ST_W-1:0] = state.status;
            ADDR_IRQ_EN:    rdData[ST_W-1:0] = state.irqEnable;
            ADDR_COUNT:     rdData[COUNT_BITS-1:0] = state.count;
            default:        rdData = 32'h0000_0000;
        endcase
    end

    wit_mode_type          mode;
    logic                  running;
    logic                  overflow;
    logic                  restart;
    logic [4:0]            shiftPos;
    logic [COUNT_BITS-1:0] countTop;
    logic [ST_W-1:0]       setBits;

    always_comb begin
        next_state = state;
        next_state.ev = '0;
        running = state.watchdogModeControl[RUN_BIT];
        // single counter, mode bit alone decides its use
        if (!state.watchdogModeControl[MODE_SEL_BIT]) begin
            mode = WIT_INTERVAL;
        end else if (!state.watchdogModeControl[OVF_ACT_BIT]) begin
            mode = WIT_WDT_NMI;
        end else begin
            mode = WIT_WDT_RESET;
        end
        shiftPos = overflowShift(
            state.overflowTimeSelect[SEL_FIELD_LSB +: SEL_FIELD_W]);
        countTop = COUNT_BITS'((13'h1 << shiftPos) - 13'h1);
        restart = wrStrobe && wrAddr == ADDR_MODE_CTRL && wrData[RUN_BIT];
        overflow = running && !stopped && prescaleTick && state.count == countTop
            && !restart;
        setBits = '0;
        // count only in prescaler steps, held in stop
        if (restart) begin
            next_state.count = '0;
        end else if (running && !stopped && prescaleTick) begin
            next_state.count = overflow ? '0 : state.count + 1'b1;
        end
        // overflow events: one-cycle irq pulses, reset request held four cycles
        if (overflow) begin
            case (mode)
                WIT_INTERVAL: begin
                    next_state.ev.maskableIrq = 1'b1;
                    next_state.ev.pwmOffIrq = 1'b1;
                    setBits[ST_MASKABLE] = 1'b1;
                end
                WIT_WDT_NMI: begin
                    next_state.ev.nmiIrq = 1'b1;
                    next_state.ev.pwmOffIrq = 1'b1;
                    setBits[ST_NMI] = 1'b1;
                end
                WIT_WDT_RESET: begin
                    next_state.resetHold = 3'(RESET_PULSE_CYC);
                    setBits[ST_RESET] = 1'b1;
                end
                default: setBits = '0;
            endcase
        end
        if (state.resetHold != 3'h0) begin
            next_state.resetHold = state.resetHold - 3'h1;
        end
        next_state.ev.systemReset = state.resetHold != 3'h0;
        // register writes
        if (wrStrobe) begin
            case (wrAddr)
                ADDR_OVF_SEL: next_state.overflowTimeSelect = wrData;
                ADDR_MODE_CTRL: begin
                    // sticky bits: only a system reset clears them
                    next_state.watchdogModeControl = wrData
                        | (state.watchdogModeControl & 8'h98);
                end
                ADDR_OSC_SEL: next_state.oscSettle = wrData;
                ADDR_IRQ_EN: next_state.irqEnable = wrData[ST_W-1:0];
                ADDR_IRQ_CLR: next_state.status = state.status & ~wrData[ST_W-1:0];
                default: next_state.status = next_state.status;
            endcase
        end
        // event set wins over a clear in the same cycle
        next_state.status = next_state.status | setBits;
        next_state.irq = |(next_state.status & state.irqEnable);
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            state <= '0;
            state.overflowTimeSelect <= OVF_SEL_RST;
            state.watchdogModeControl <= MODE_CTRL_RST;
            state.oscSettle <= OSC_SEL_RST;
        end else begin
            state <= next_state;
        end
    end

    assign awready = axiOut.awready;
    assign wready = axiOut.wready;
    assign bvalid = axiOut.bvalid;
    assign bresp = axiOut.bresp;
    assign arready = axiOut.arready;
    assign rvalid = axiOut.rvalid;
    assign rdata = axiOut.rdata;
    assign rresp = axiOut.rresp;
    assign overflowIrq = state.ev.maskableIrq;
    assign nmiRequest = state.ev.nmiIrq;
    assign systemResetReq = state.ev.systemReset;
    assign pwmOffIrq = state.ev.pwmOffIrq;
    assign irq = state.irq;
    assign oscSettleSelect = state.oscSettle;
endmodule

//--- test/wit_top_props.sv
// concurrent checks on the watchdog interval timer ports
`timescale 1ns/1ps
module wit_props
    import wit_pkg::*;
(
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       sys_rst,
    // timer events
    input wire logic       overflowIrq,
    input wire logic       nmiRequest,
    input wire logic       systemResetReq,
    input wire logic       pwmOffIrq,
    input wire logic [7:0] oscSettleSelect
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    property p_ovf_pulse;
        overflowIrq |=> !overflowIrq;
    endproperty
    a_ovf_pulse: assert property (p_ovf_pulse) else $error("overflow pulse too long");
    property p_nmi_pulse;
        nmiRequest |=> !nmiRequest;
    endproperty
    a_nmi_pulse: assert property (p_nmi_pulse) else $error("nmi pulse too long");
    property p_pwm_follow;
        (overflowIrq || nmiRequest) |-> pwmOffIrq;
    endproperty
    a_pwm_follow: assert property (p_pwm_follow) else $error("pwm off missing");
    property p_pwm_only;
        pwmOffIrq |-> (overflowIrq || nmiRequest) && !systemResetReq;
    endproperty
    a_pwm_only: assert property (p_pwm_only) else $error("pwm off without irq");
    property p_excl;
        overflowIrq |-> !nmiRequest;
    endproperty
    a_excl: assert property (p_excl) else $error("both irq kinds at once");
    property p_rst_no_irq;
        systemResetReq |-> !overflowIrq && !nmiRequest;
    endproperty
    a_rst_no_irq: assert property (p_rst_no_irq) else $error("irq in reset mode");
    property p_rst_width;
        $rose(systemResetReq) |-> systemResetReq[*4] ##1 !systemResetReq;
    endproperty
    a_rst_width: assert property (p_rst_width) else $error("reset request width");
    property p_osc_rst;
        $fell(sys_rst) |-> oscSettleSelect == 8'h04;
    endproperty
    a_osc_rst: assert property (p_osc_rst) else $error("osc settle reset value");
endmodule

bind wit_top wit_props u_props (
    .sys_clk        (sys_clk),
    .sys_rst        (sys_rst),
    .overflowIrq    (overflowIrq),
    .nmiRequest     (nmiRequest),
    .systemResetReq (systemResetReq),
    .pwmOffIrq      (pwmOffIrq),
    .oscSettleSelect(oscSettleSelect)
);

//--- test/wit_top_tb.sv
// self-checking bench for the watchdog interval timer
`timescale 1ns/1ps
module wit_top_tb
    import wit_pkg::*;
;
    logic        sys_clk, sys_rst, cpuHalt, cpuStop, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]  awaddr, araddr, oscSettleSelect;
    logic [31:0] wdata, rdata, rv;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic        overflowIrq, nmiRequest, systemResetReq, pwmOffIrq;
    logic [2:0]  ev, evP = 3'h0;
    int          nMismatch = 0, compares = 0, cyc = 0, tW, t1, t2;
    int          cnt[3] = '{0, 0, 0}, lastT[3], mReg[8] = '{0, 0, 4, 0, 0, 0, 0, 0};

    wit_top u_wit_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .cpuHalt(cpuHalt),
        .cpuStop(cpuStop), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
        .bresp(bresp), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rvalid(rvalid), .rdata(rdata), .rresp(rresp), .rready(rready),
        .overflowIrq(overflowIrq), .nmiRequest(nmiRequest), .systemResetReq(systemResetReq),
        .pwmOffIrq(pwmOffIrq), .irq(irq), .oscSettleSelect(oscSettleSelect));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // event monitor: rising edges counted with their cycle
    assign ev = {systemResetReq, nmiRequest, overflowIrq};
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        evP <= ev;
        for (int k = 0; k < 3; k++) begin
            if (ev[k] && !evP[k]) begin
                cnt[k] <= cnt[k] + 1;
                lastT[k] <= cyc;
            end
        end
    end

    task give_verdict;
        $display("compares %0d mismatches %0d", compares, nMismatch);
        if (nMismatch == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            nMismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // register model: run, mode select and action bits only ever set
    function automatic void mwrite(input logic [7:0] a, input logic [31:0] d);
        case (a)
            ADDR_OVF_SEL:   mReg[0] = d[7:0];
            ADDR_MODE_CTRL: mReg[1] = (d[7:0] & 8'h67) | ((mReg[1] | d[7:0]) & 8'h98);
            ADDR_OSC_SEL:   mReg[2] = d[7:0];
            ADDR_IRQ_EN:    mReg[4] = d[2:0];
            default: ;
        endcase
    endfunction

    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        cpuHalt <= 1'($urandom);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid && n < 100);
        bready <= 1'b0;
        chk({bvalid, bresp}, {1'b1, er});
        if (er == RESP_OKAY) mwrite(a, d);
        tW = cyc;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] m, input logic [1:0] er,
            input logic [31:0] e);
        int n;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid && n < 100);
        rready <= 1'b0;
        rv = rdata;
        chk({rvalid, rresp}, {1'b1, er});
        chk(rdata & m, e & m);
    endtask

    task wait_ev(input int k, input int lim, output int t);
        int c0, n;
        c0 = cnt[k];
        n = 0;
        while (cnt[k] == c0 && n < lim) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        t = lastT[k];
        chk(32'(cnt[k] - c0), 1);
    endtask

    initial begin
        repeat (100000) @(posedge sys_clk);
        nMismatch++;
        give_verdict;
    end

    initial begin
        int p, a, c0;
        void'($urandom(32'h85cc));
        {sys_rst, cpuHalt, cpuStop, awvalid, wvalid, bready, arvalid, rready} = 8'h80;
        {awaddr, araddr, wdata, wstrb} = 52'h0000000000F;
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        rd(ADDR_OVF_SEL, 32'hFF, RESP_OKAY, 0);
        rd(ADDR_MODE_CTRL, 32'hFF, RESP_OKAY, 0);
        rd(ADDR_OSC_SEL, 32'hFF, RESP_OKAY, 8'h04);
        chk(oscSettleSelect, 8'h04);
        rd(8'h1C, 32'hFFFFFFFF, RESP_SLVERR, 0);
        wr(8'h1C, 32'h80, RESP_SLVERR);
        repeat (600) @(posedge sys_clk);
        rd(ADDR_COUNT, 32'hFFF, RESP_OKAY, 0);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_OVF_SEL, $urandom, RESP_OKAY);
            rd(ADDR_OVF_SEL, 32'h7, RESP_OKAY, mReg[0]);
            wr(ADDR_OSC_SEL, $urandom, RESP_OKAY);
            rd(ADDR_OSC_SEL, 32'hFF, RESP_OKAY, mReg[2]);
            chk(oscSettleSelect, mReg[2]);
        end
        wr(ADDR_IRQ_EN, 32'h1, RESP_OKAY);
        for (int c = 0; c < 3; c++) begin
            p = 4096 << c;
            wr(ADDR_OVF_SEL, c, RESP_OKAY);
            wr(ADDR_MODE_CTRL, 32'h80, RESP_OKAY);
            wait_ev(0, p + 50, t1);
            chk(32'(t1 - tW >= p - 264 && t1 - tW <= p + 8), 1);
            wait_ev(0, p + 50, t2);
            chk(32'(t2 - t1), p);
        end
        wr(ADDR_OVF_SEL, 0, RESP_OKAY);
        wr(ADDR_MODE_CTRL, 32'h80, RESP_OKAY);
        wr(ADDR_MODE_CTRL, 32'h00, RESP_OKAY);
        rd(ADDR_MODE_CTRL, 32'hFF, RESP_OKAY, mReg[1]);
        wait_ev(0, 4400, t1);
        repeat (3) @(posedge sys_clk);
        chk(irq, 1'b1);
        rd(ADDR_STATUS, 32'h7, RESP_OKAY, 1);
        wr(ADDR_IRQ_CLR, 32'h1, RESP_OKAY);
        repeat (2) @(posedge sys_clk);
        chk(irq, 1'b0);
        wr(ADDR_IRQ_EN, 32'h0, RESP_OKAY);
        wait_ev(0, 4400, t1);
        repeat (3) @(posedge sys_clk);
        chk(irq, 1'b0);
        rd(ADDR_STATUS, 32'h7, RESP_OKAY, 1);
        wr(ADDR_MODE_CTRL, 32'h80, RESP_OKAY);
        cpuStop <= 1'b1;
        repeat (8) @(posedge sys_clk);
        rd(ADDR_COUNT, 32'h0, RESP_OKAY, 0);
        a = rv;
        repeat (1000) @(posedge sys_clk);
        rd(ADDR_COUNT, 32'hFFF, RESP_OKAY, a);
        cpuStop <= 1'b0;
        wr(ADDR_IRQ_EN, 32'h7, RESP_OKAY);
        wr(ADDR_MODE_CTRL, 32'h90, RESP_OKAY);
        wr(ADDR_MODE_CTRL, 32'h80, RESP_OKAY);
        rd(ADDR_MODE_CTRL, 32'hFF, RESP_OKAY, mReg[1]);
        c0 = cnt[1];
        a = cnt[0];
        repeat (4) begin
            repeat (3000) @(posedge sys_clk);
            wr(ADDR_MODE_CTRL, 32'h90, RESP_OKAY);
        end
        chk(cnt[1], c0);
        wait_ev(1, 4200, t1);
        chk(32'(t1 - tW >= 4096 - 264 && t1 - tW <= 4096 + 8), 1);
        chk(cnt[0], a);
        rd(ADDR_STATUS, 32'h2, RESP_OKAY, 2);
        wr(ADDR_MODE_CTRL, 32'h98, RESP_OKAY);
        wait_ev(2, 4400, t1);
        chk(cnt[1], c0 + 1);
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        mReg = '{0, 0, 4, 0, 0, 0, 0, 0};
        rd(ADDR_MODE_CTRL, 32'hFF, RESP_OKAY, mReg[1]);
        rd(ADDR_OVF_SEL, 32'hFF, RESP_OKAY, mReg[0]);
        rd(ADDR_OSC_SEL, 32'hFF, RESP_OKAY, mReg[2]);
        chk(oscSettleSelect, 8'h04);
        give_verdict;
    end
endmodule
